// ### core/edpc_regs.svh
// Register offset, field positions, reset values and timing for energy detect
`ifndef EDPC_REGS_SVH
`define EDPC_REGS_SVH
`define EDPC_ADDR_CTRL 5'h1D
`define EDPC_BIT_EN 15
`define EDPC_BIT_AUTO_UP 14
`define EDPC_BIT_AUTO_DOWN 13
`define EDPC_BIT_MAN 12
`define EDPC_BIT_BURST_DIS 11
`define EDPC_BIT_PWR_STATE 10
`define EDPC_BIT_ERR_MET 9
`define EDPC_BIT_DATA_MET 8
`define EDPC_ERR_HI 7
`define EDPC_ERR_LO 4
`define EDPC_DATA_HI 3
`define EDPC_DATA_LO 0
`define EDPC_THR_RST 4'h1
`define EDPC_CNT_ZERO 4'h0
`define EDPC_CNT_MAX 4'hF
`define EDPC_BURST_LONG 3'h4
`define EDPC_BURST_ONE 3'h1
`define EDPC_QUIET_MS 2000
`define EDPC_CLK_KHZ 20000
`endif

// ### core/edpc_pkg.sv
// Types shared by the energy detect power control block
package edpc_pkg;
    // Energy detect power state
    typedef enum logic [1:0] {
        EDPC_DOWN = 2'b00,
        EDPC_GO_UP = 2'b01,
        EDPC_UP = 2'b10,
        EDPC_GO_DOWN = 2'b11
    } edpc_state_t;
endpackage

// ### core/edpc_pulse_gen.sv
// Energy detect data pulse burst generator
`timescale 1ns/1ns
`include "edpc_regs.svh"
module edpc_pulse_gen
    import edpc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic start,
    input wire logic burst_disable,
    output logic pulse,
    output logic busy
);
    // Pulses still to send
    logic [2:0] left_r;
    // Pulse output register
    logic pulse_r;

    // Load the burst length on driver power-up, then count it down
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            left_r <= 3'h0;
            pulse_r <= 1'b0;
        end else if (start) begin
            // One pulse or a burst of four
            left_r <= burst_disable ? `EDPC_BURST_ONE : `EDPC_BURST_LONG;
            pulse_r <= 1'b0;
        end else if (pulse_r) begin
            // Gap cycle between pulses
            pulse_r <= 1'b0;
        end else if (left_r != 3'h0) begin
            pulse_r <= 1'b1;
            left_r <= left_r - 3'h1;
        end
    end

    assign pulse = pulse_r;
    assign busy = (left_r != 3'h0) || pulse_r;
endmodule // edpc_pulse_gen

// ### core/edpc_ctrl.sv
// Energy detect control register and power state sequencing
// Operation
// - Manual trigger starts a power transition, which completes on power_seq_done
// - Burst of four pulses per driver power-up
// - Burst disable sends single pulse
// - Read-only bit shows powered-up state
// - Error met flag informational, clear on read
// - Data met flag when count reaches threshold
// - Error threshold bits 7:4, reset 0001
// - Data threshold bits 3:0, reset 0001
// - Counters clear after two quiet seconds
// - Auto power-up at data threshold
// - Auto power-down when no energy
`timescale 1ns/1ns
`include "edpc_regs.svh"
module edpc_ctrl
    import edpc_pkg::*;
#(
    // Quiet time before counters clear, in clock cycles
    parameter int unsigned QUIET_CYCLES = `EDPC_QUIET_MS * `EDPC_CLK_KHZ
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [4:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    input wire logic data_event,
    input wire logic error_event,
    input wire logic energy_present,
    input wire logic power_seq_done,
    output logic transmit_driver_on,
    output logic ed_pulse,
    output logic power_state_flag
);
    // Register fields
    logic enable_r;
    logic auto_power_up_r;
    logic auto_power_down_r;
    logic manual_power_trigger_r;
    logic pulse_burst_disable_r;
    logic error_threshold_met_r;
    logic data_threshold_met_r;
    logic [3:0] error_threshold_r;
    logic [3:0] data_threshold_r;
    // Event counters and quiet timer
    logic [3:0] data_cnt_r;
    logic [3:0] err_cnt_r;
    logic [31:0] quiet_r;
    // Power state
    edpc_state_t state_r;
    edpc_state_t state_nxt;
    // Decoded strobes
    logic hit;
    logic wr_hit;
    logic rd_hit;
    logic quiet_done;
    logic data_met;
    logic err_met;
    logic man_start;
    logic up_start;

    // Saturating increment used by both counters
    function automatic logic [3:0] sat_inc(input logic [3:0] v,
                                           input logic ev);
        sat_inc = (ev && v != `EDPC_CNT_MAX) ? v + 4'h1 : v;
    endfunction

    assign hit = (reg_addr == `EDPC_ADDR_CTRL);
    assign wr_hit = reg_wr && hit;
    assign rd_hit = reg_rd && hit;
    assign quiet_done = (quiet_r >= QUIET_CYCLES - 1);
    // Threshold comparison, count at or above threshold
    assign data_met = (data_cnt_r >= data_threshold_r);
    assign err_met = (err_cnt_r >= error_threshold_r);
    // Manual trigger starts a transition from either settled state
    assign man_start = manual_power_trigger_r && enable_r &&
        (state_r == EDPC_DOWN || state_r == EDPC_UP);

    // Software writable fields
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            enable_r <= 1'b0;
            auto_power_up_r <= 1'b1;
            auto_power_down_r <= 1'b1;
            pulse_burst_disable_r <= 1'b0;
            error_threshold_r <= `EDPC_THR_RST;
            data_threshold_r <= `EDPC_THR_RST;
        end else if (wr_hit) begin
            enable_r <= reg_wdata[`EDPC_BIT_EN];
            auto_power_up_r <= reg_wdata[`EDPC_BIT_AUTO_UP];
            auto_power_down_r <= reg_wdata[`EDPC_BIT_AUTO_DOWN];
            pulse_burst_disable_r <= reg_wdata[`EDPC_BIT_BURST_DIS];
            error_threshold_r <= reg_wdata[`EDPC_ERR_HI:`EDPC_ERR_LO];
            data_threshold_r <= reg_wdata[`EDPC_DATA_HI:`EDPC_DATA_LO];
        end
    end

    // Manual trigger: set by write, cleared when its transition starts
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            manual_power_trigger_r <= 1'b0;
        end else if (wr_hit && reg_wdata[`EDPC_BIT_MAN]) begin
            manual_power_trigger_r <= 1'b1;
        end else if (man_start || !enable_r) begin
            manual_power_trigger_r <= 1'b0;
        end
    end

    // Quiet timer, restarted by every data event
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            quiet_r <= 32'h0;
        end else if (data_event || quiet_done) begin
            quiet_r <= 32'h0;
        end else begin
            quiet_r <= quiet_r + 32'h1;
        end
    end

    // Event counters, cleared after quiet period or a power transition
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            data_cnt_r <= `EDPC_CNT_ZERO;
            err_cnt_r <= `EDPC_CNT_ZERO;
        end else if (quiet_done || state_r != state_nxt) begin
            data_cnt_r <= `EDPC_CNT_ZERO;
            err_cnt_r <= `EDPC_CNT_ZERO;
        end else if (enable_r) begin
            data_cnt_r <= sat_inc(data_cnt_r, data_event);
            err_cnt_r <= sat_inc(err_cnt_r, error_event);
        end
    end

    // Clear-on-read flags; a new threshold hit wins over the read clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            error_threshold_met_r <= 1'b0;
            data_threshold_met_r <= 1'b0;
        end else begin
            if (enable_r && err_met) begin
                error_threshold_met_r <= 1'b1;
            end else if (rd_hit) begin
                error_threshold_met_r <= 1'b0;
            end
            if (enable_r && data_met) begin
                data_threshold_met_r <= 1'b1;
            end else if (rd_hit) begin
                data_threshold_met_r <= 1'b0;
            end
        end
    end

    // Next power state; error threshold causes no transition
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            EDPC_DOWN: begin
                if (man_start) begin
                    state_nxt = EDPC_GO_UP;
                end else if (enable_r && auto_power_up_r && data_met) begin
                    state_nxt = EDPC_GO_UP;
                end
            end
            EDPC_GO_UP: begin
                if (power_seq_done) begin
                    state_nxt = EDPC_UP;
                end
            end
            EDPC_UP: begin
                if (man_start) begin
                    state_nxt = EDPC_GO_DOWN;
                end else if (enable_r && auto_power_down_r &&
                             !energy_present) begin
                    state_nxt = EDPC_GO_DOWN;
                end
            end
            EDPC_GO_DOWN: begin
                if (power_seq_done) begin
                    state_nxt = EDPC_DOWN;
                end
            end
            default: begin
                state_nxt = EDPC_DOWN;
            end
        endcase
    end

    // Power state register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= EDPC_DOWN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Driver on and pulse burst start on entering power-up
    assign up_start = (state_r == EDPC_DOWN) && (state_nxt == EDPC_GO_UP);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            transmit_driver_on <= 1'b0;
        end else begin
            transmit_driver_on <= (state_nxt == EDPC_GO_UP) ||
                (state_nxt == EDPC_UP);
        end
    end

    edpc_pulse_gen u_pulse (
        .clk(clk),
        .nrst(nrst),
        .start(up_start),
        .burst_disable(pulse_burst_disable_r),
        .pulse(ed_pulse),
        .busy()
    );

    // Powered-up indication
    assign power_state_flag = (state_r == EDPC_UP);

    // Read data register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 16'h0000;
        end else if (rd_hit) begin
            reg_rdata <= {enable_r, auto_power_up_r, auto_power_down_r,
                manual_power_trigger_r, pulse_burst_disable_r,
                power_state_flag, error_threshold_met_r,
                data_threshold_met_r, error_threshold_r,
                data_threshold_r};
        end else if (reg_rd) begin
            reg_rdata <= 16'h0000;
        end
    end
endmodule // edpc_ctrl

// ### tb/edpc_ctrl_properties.sv
// Port-level property checker for the energy detect control block
`timescale 1ns/1ns
module edpc_ctrl_properties (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [4:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic transmit_driver_on,
    input wire logic ed_pulse,
    input wire logic power_state_flag
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic hit;
    logic [2:0] npulse_r; // Pulses since the driver last powered up
    assign hit = reg_addr == 5'h1D;
    // Count pulses per power-up, saturating so a runaway still shows
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            npulse_r <= 3'h0;
        else if ($rose(transmit_driver_on))
            npulse_r <= 3'h0;
        else if (ed_pulse && npulse_r != 3'h7)
            npulse_r <= npulse_r + 3'h1;
    end
    AST_UNMAPPED_READ: assert property (reg_rd && !hit |=> reg_rdata == 16'h0)
        else $error("unmapped read not zero");
    AST_RDATA_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    AST_THR_READBACK: assert property (
        reg_wr && hit ##1 reg_rd && hit
        |=> reg_rdata[7:0] == $past(reg_wdata[7:0], 2))
        else $error("threshold readback wrong");
    AST_STATE_READ: assert property (
        reg_rd && hit |=> reg_rdata[10] == $past(power_state_flag))
        else $error("power state bit wrong");
    AST_UP_AFTER_DRIVER: assert property (
        $rose(power_state_flag) |-> $past(transmit_driver_on))
        else $error("up state without driver power-up");
    AST_PULSE_GAP: assert property (ed_pulse |=> !ed_pulse)
        else $error("pulses not separated");
    AST_BURST_MAX: assert property (npulse_r <= 3'h4)
        else $error("too many pulses in one burst");
    AST_BURST_START: assert property (
        $rose(transmit_driver_on) |-> ##[0:4] ed_pulse)
        else $error("no pulse after driver power-up");
endmodule // edpc_ctrl_properties
bind edpc_ctrl edpc_ctrl_properties i_props (.clk(clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .transmit_driver_on(transmit_driver_on), .ed_pulse(ed_pulse),
    .power_state_flag(power_state_flag));

// ### tb/tb_top.sv
// Self-checking bench for the energy detect control block
`timescale 1ns/1ns
module tb_top;
    logic clk, nrst, reg_wr, reg_rd, data_event, error_event;
    logic energy_present, power_seq_done, transmit_driver_on;
    logic ed_pulse, power_state_flag;
    logic [4:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, ctl; // ctl: model of writable bits
    logic [31:0] seed;
    int fail_count, comparisons, n;
    edpc_ctrl #(.QUIET_CYCLES(50)) i_edpc_ctrl (.clk(clk), .nrst(nrst),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .data_event(data_event), .error_event(error_event),
        .energy_present(energy_present), .power_seq_done(power_seq_done),
        .transmit_driver_on(transmit_driver_on), .ed_pulse(ed_pulse),
        .power_state_flag(power_state_flag));
    // Clock generator
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #5;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        comparisons++;
        if (seen !== want) begin
            fail_count++;
            $display("mismatch at %0t: got %h want %h", $time, seen, want);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        cyc(1);
        reg_wr = 1'b0;
        if (a == 5'h1D)
            ctl = d & 16'hEFFF; // Manual bit reads back cleared
    endtask
    task automatic rd(input logic [4:0] a, input logic st, em, dm);
        reg_addr = a;
        reg_rd = 1'b1;
        cyc(1);
        reg_rd = 1'b0;
        check(reg_rdata, (a != 5'h1D) ? 16'h0 :
            {ctl[15:13], 1'b0, ctl[11], st, em, dm, ctl[7:0]});
        cyc(1); // Idle edge keeps back-to-back reads apart
    endtask
    task automatic events(input int k, input logic err);
        repeat (k) begin
            data_event = !err;
            error_event = err;
            cyc(1);
            data_event = 1'b0;
            error_event = 1'b0;
            cyc(1);
        end
    endtask
    task automatic wait_drv(input logic v);
        for (int i = 0; i < 50 && transmit_driver_on !== v; i++)
            cyc(1);
        check({15'h0, transmit_driver_on}, {15'h0, v});
        // A driver that never settles ends the run at the report
        if (transmit_driver_on !== v)
            give_verdict();
    endtask
    task automatic seq_done();
        power_seq_done = 1'b1;
        cyc(1);
        power_seq_done = 1'b0;
        cyc(2);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Main sequence
    initial begin
        {nrst, reg_wr, reg_rd, data_event, error_event} = 5'h0;
        {energy_present, power_seq_done, reg_addr, reg_wdata} = 23'h0;
        ctl = 16'h6011;
        seed = 32'hcc73;
        repeat (16) @(posedge clk);
        #5 nrst = 1'b1;
        rd(5'h1D, 0, 0, 0);
        wr(5'h1C, 16'hFFFF);
        rd(5'h1C, 0, 0, 0);
        rd(5'h1D, 0, 0, 0);
        repeat (4) begin
            seed = xs(seed);
            wr(5'h1D, (seed[15:0] & 16'h78FF) | 16'h0011);
            cyc(3);
            rd(5'h1D, 0, 0, 0);
            // Read straight after a write, manual bit kept clear
            seed = xs(seed);
            wr(5'h1D, (seed[15:0] & 16'h68FF) | 16'h0011);
            rd(5'h1D, 0, 0, 0);
        end
        for (int b = 0; b < 2; b++) begin
            wr(5'h1D, b ? 16'h9811 : 16'h9011);
            n = 0;
            repeat (24) begin
                if (ed_pulse === 1'b1)
                    n++;
                cyc(1);
            end
            check(16'(n), b ? 16'h1 : 16'h4);
            wait_drv(1);
            seq_done();
            rd(5'h1D, 1, 0, 0);
            wr(5'h1D, ctl | 16'h1000);
            wait_drv(0);
            seq_done();
            rd(5'h1D, 0, 0, 0);
        end
        wr(5'h1D, 16'h8022);
        events(1, 0);
        rd(5'h1D, 0, 0, 0);
        events(1, 0);
        rd(5'h1D, 0, 0, 1);
        events(2, 1);
        rd(5'h1D, 0, 1, 1);
        cyc(60);
        rd(5'h1D, 0, 1, 1);
        rd(5'h1D, 0, 0, 0);
        energy_present = 1'b1;
        wr(5'h1D, 16'hE013);
        events(2, 0);
        check({15'h0, transmit_driver_on}, 16'h0);
        events(1, 0);
        wait_drv(1);
        seq_done();
        check({15'h0, power_state_flag}, 16'h1);
        energy_present = 1'b0;
        wait_drv(0);
        seq_done();
        check({15'h0, power_state_flag}, 16'h0);
        give_verdict();
    end
endmodule // tb_top
